// >>> core/ocm_top.v
/*
 override compensation mapper: spindle override scaling, machine error
 compensation and arbitrary data mapping, with an apb register slave.
 assumes all inputs synchronous to pclk; link qualifiers come from the
 optical link receiver, panel and speed values from the controller.
*/
`timescale 1ns/1ps
`include "ocm_defines.vh"

module ocm_top #(
	parameter NUM_IDS = 20,
	parameter IDX_W = 7
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output reg pslverr,
	input wire link_active,
	input wire cycle_start,
	input wire ctrl_reset,
	input wire emergency_stop,
	input wire ctrl_start,
	input wire [15:0] panel_spindle_ovr,
	input wire [31:0] auto_spindle_speed,
	input wire spindle_factor_valid,
	input wire [15:0] spindle_factor,
	input wire mec_valid,
	input wire [31:0] mec_value,
	input wire [31:0] mec_existing,
	input wire rec_valid,
	input wire [15:0] rec_id,
	input wire [63:0] rec_data,
	output reg [31:0] spindle_speed_out,
	output reg [15:0] spindle_ovr_out,
	output reg spindle_comp_active_flag,
	output reg [31:0] mec_total_out,
	output reg machine_err_comp_flag_a,
	output reg machine_err_comp_flag_b,
	output wire irq
);

	//////////////////////////////////////////////////////////////////////////////
	// percent scaling, saturating at full width
	function [31:0] pct_scale;
		input [31:0] val;
		input [15:0] pct;
		reg [47:0] prod;
		reg [47:0] quot;
		begin
			prod = {16'h0000, val} * {32'h00000000, pct};
			quot = prod / {32'h00000000, `OCM_PCT_FULL};
			if (quot[47:32] != 16'h0000) begin
				pct_scale = 32'hFFFFFFFF;
			end else begin
				pct_scale = quot[31:0];
			end
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// spindle factor selection
	reg [15:0] sp_limit_r;
	reg [15:0] spf_eff;
	reg spf_fixed;
	wire spf_use = cycle_start && link_active && spindle_factor_valid;

	always @* begin
		spf_eff = `OCM_SPF_DEFAULT;
		spf_fixed = 1'b0;
		if (spf_use) begin
			if (spindle_factor[15]) begin
				spf_eff = `OCM_SPF_DEFAULT;
				spf_fixed = 1'b1;
			end else if (spindle_factor > `OCM_SPF_MAX) begin
				spf_eff = `OCM_SPF_MAX;
				spf_fixed = 1'b1;
			end else begin
				spf_eff = spindle_factor;
			end
		end
	end

	// panel override first, factor second
	wire [31:0] ovr_scaled = pct_scale({16'h0000, panel_spindle_ovr}, spf_eff);
	wire [15:0] ovr_clamped = (ovr_scaled > {16'h0000, sp_limit_r}) ? sp_limit_r :
		ovr_scaled[15:0];

	//////////////////////////////////////////////////////////////////////////////
	// machine error, 1/20000 mm steps with no inch conversion
	// controller reset and emergency stop deliberately do not gate this path
	wire mec_use = link_active && mec_valid;
	wire signed [31:0] mec_in = mec_value;
	wire signed [31:0] mec_pos = `OCM_MEC_ONE_MM;
	wire signed [31:0] mec_neg = -mec_pos;
	reg [31:0] mec_eff;
	reg mec_clamped;

	always @* begin
		mec_eff = `OCM_MEC_DEFAULT;
		mec_clamped = 1'b0;
		if (mec_use) begin
			if (mec_in > mec_pos) begin
				mec_eff = mec_pos;
				mec_clamped = 1'b1;
			end else if (mec_in < mec_neg) begin
				mec_eff = mec_neg;
				mec_clamped = 1'b1;
			end else begin
				mec_eff = mec_value;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// compensation outputs
	reg [31:0] mec_applied_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spindle_ovr_out <= 16'h0000;
			spindle_speed_out <= 32'h00000000;
			spindle_comp_active_flag <= 1'b0;
		end else begin
			spindle_ovr_out <= ovr_clamped;
			spindle_speed_out <= pct_scale(auto_spindle_speed, ovr_clamped);
			spindle_comp_active_flag <= spf_use;
		end
	end

	// applied value kept apart so a read is not skewed by a moving existing value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mec_total_out <= 32'h00000000;
			mec_applied_r <= 32'h00000000;
			machine_err_comp_flag_a <= 1'b0;
			machine_err_comp_flag_b <= 1'b0;
		end else begin
			mec_total_out <= mec_existing + mec_eff;
			mec_applied_r <= mec_eff;
			machine_err_comp_flag_a <= mec_use;
			machine_err_comp_flag_b <= mec_use;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// arbitrary data store
	wire rec_take = rec_valid && link_active;
	wire rec_id_ok;
	wire [15:0] arb_word;
	wire [11:0] arb_off = paddr - `OCM_OFF_ARB_BASE;
	wire [IDX_W-1:0] arb_idx = arb_off[IDX_W+1:2];
	reg [15:0] last_id_r;

	ocm_arb_store #(
		.NUM_IDS(NUM_IDS),
		.IDX_W(IDX_W)
	) u_store (
		.pclk(pclk),
		.presetn(presetn),
		.clear(ctrl_start),
		.wr_en(rec_take),
		.wr_id(rec_id),
		.wr_data(rec_data),
		.rd_idx(arb_idx),
		.rd_word(arb_word),
		.id_ok(rec_id_ok)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_id_r <= 16'h0000;
		end else if (rec_take && rec_id_ok) begin
			last_id_r <= rec_id;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// interrupt events; factor fix and error clamp edge detected so a standing condition fires once, record events level
	reg spf_fixed_d_r;
	reg mec_clamped_d_r;
	reg [`OCM_IRQ_W-1:0] irq_stat_r;
	reg [`OCM_IRQ_W-1:0] irq_stat_nxt;
	reg [`OCM_IRQ_W-1:0] irq_mask_r;
	reg [`OCM_IRQ_W-1:0] irq_evt;

	always @* begin
		irq_evt = {`OCM_IRQ_W{1'b0}};
		irq_evt[`OCM_IRQ_STORED] = rec_take && rec_id_ok;
		irq_evt[`OCM_IRQ_IGNORED] = rec_take && !rec_id_ok;
		irq_evt[`OCM_IRQ_SPF_FIX] = spf_fixed && !spf_fixed_d_r;
		irq_evt[`OCM_IRQ_MEC_CLAMP] = mec_clamped && !mec_clamped_d_r;
	end

	//////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	// map helpers shared by the write strobes and the error decode
	function reg_known;
		input [11:0] addr;
		begin
			case (addr)
				`OCM_OFF_IRQ_STAT, `OCM_OFF_IRQ_MASK, `OCM_OFF_STATUS,
				`OCM_OFF_SP_OVR, `OCM_OFF_MEC_APPLIED, `OCM_OFF_SP_LIMIT,
				`OCM_OFF_LAST_ID: begin
					reg_known = 1'b1;
				end
				default: begin
					reg_known = 1'b0;
				end
			endcase
		end
	endfunction

	function reg_writable;
		input [11:0] addr;
		begin
			case (addr)
				`OCM_OFF_IRQ_STAT, `OCM_OFF_IRQ_MASK, `OCM_OFF_SP_LIMIT: begin
					reg_writable = 1'b1;
				end
				default: begin
					reg_writable = 1'b0;
				end
			endcase
		end
	endfunction

	wire apb_setup = psel && !penable;
	// only writable words commit; a refused write leaves every register alone
	wire apb_wr = psel && penable && pwrite && reg_writable(paddr);
	wire wr_irq_stat = apb_wr && (paddr == `OCM_OFF_IRQ_STAT);
	wire wr_irq_mask = apb_wr && (paddr == `OCM_OFF_IRQ_MASK);
	wire wr_sp_limit = apb_wr && (paddr == `OCM_OFF_SP_LIMIT);
	wire arb_hit = (paddr >= `OCM_OFF_ARB_BASE) &&
		(paddr < `OCM_OFF_ARB_BASE + NUM_IDS * 16) && (paddr[1:0] == 2'b00);
	reg [31:0] prdata_nxt;
	reg pslverr_nxt;

	assign pready = 1'b1;
	assign irq = |(irq_stat_r & irq_mask_r);

	always @* begin
		// set wins over a write-one clear in the same cycle
		irq_stat_nxt = irq_stat_r;
		if (wr_irq_stat) begin
			irq_stat_nxt = irq_stat_r & ~pwdata[`OCM_IRQ_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | irq_evt;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= {`OCM_IRQ_W{1'b0}};
			spf_fixed_d_r <= 1'b0;
			mec_clamped_d_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			spf_fixed_d_r <= spf_fixed;
			mec_clamped_d_r <= mec_clamped;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= {`OCM_IRQ_W{1'b0}};
		end else if (wr_irq_mask) begin
			irq_mask_r <= pwdata[`OCM_IRQ_W-1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_limit_r <= `OCM_SP_LIMIT_RST;
		end else if (wr_sp_limit) begin
			sp_limit_r <= pwdata[15:0];
		end
	end

	// read data and error decoded from the setup address
	always @* begin
		prdata_nxt = 32'h00000000;
		pslverr_nxt = 1'b0;
		if (arb_hit) begin
			prdata_nxt = {16'h0000, arb_word};
			pslverr_nxt = pwrite;
		end else if (!reg_known(paddr)) begin
			pslverr_nxt = 1'b1;
		end else begin
			pslverr_nxt = pwrite && !reg_writable(paddr);
			case (paddr)
				`OCM_OFF_IRQ_STAT: begin
					prdata_nxt = {28'h0000000, irq_stat_r};
				end
				`OCM_OFF_IRQ_MASK: begin
					prdata_nxt = {28'h0000000, irq_mask_r};
				end
				`OCM_OFF_STATUS: begin
					prdata_nxt = {28'h0000000, link_active, machine_err_comp_flag_b,
						machine_err_comp_flag_a, spindle_comp_active_flag};
				end
				`OCM_OFF_SP_OVR: begin
					prdata_nxt = {16'h0000, spindle_ovr_out};
				end
				`OCM_OFF_MEC_APPLIED: begin
					prdata_nxt = mec_applied_r;
				end
				`OCM_OFF_SP_LIMIT: begin
					prdata_nxt = {16'h0000, sp_limit_r};
				end
				`OCM_OFF_LAST_ID: begin
					prdata_nxt = {16'h0000, last_id_r};
				end
				default: begin
					prdata_nxt = 32'h00000000;
				end
			endcase
		end
	end

	// latched in setup and held through access, so the access edge sees one value
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (apb_setup) begin
			prdata <= prdata_nxt;
			pslverr <= pslverr_nxt;
		end
	end

endmodule

// >>> core/ocm_defines.vh
/*
 constants for the override compensation mapper: register offsets, reset values,
 limits and record identifier ranges.
 assumes inclusion by bare name from the design files; definitions only.
*/
//////////////////////////////////////////////////////////////////////////////
// Operation
// - apply panel spindle override first, then scale by the module factor.
// - clamp scaled override at its limit; active flag on while scaling applies.
// - factor used only with cycle start, link active and value supplied; else 100%.
// - factor below 0% is replaced by the 100% default, not clamped.
// - factor above 200% is clamped to 200%.
// - machine error units are always 1/20000 mm, inch or metric alike.
// - machine error value stays applied during controller reset and emergency stop.
// - both machine error flags on while the module value is applied.
// - machine error applied when link active and value supplied; else 0 mm.
// - 8-byte record split into four 2-byte words, four consecutive word registers.
// - word registers update only with link active and record supplied; else hold.
// - controller start clears every arbitrary data word register to zero.
// - ids 0x2300-0x230F then 0x2400-0x2403 map to successive groups of four.
// - at most 20 identifiers, 160 bytes of arbitrary data in total.
//////////////////////////////////////////////////////////////////////////////
`ifndef OCM_DEFINES_VH
`define OCM_DEFINES_VH

`define OCM_OFF_IRQ_STAT 12'h000
`define OCM_OFF_IRQ_MASK 12'h004
`define OCM_OFF_STATUS 12'h008
`define OCM_OFF_SP_OVR 12'h00C
`define OCM_OFF_MEC_APPLIED 12'h010
`define OCM_OFF_SP_LIMIT 12'h014
`define OCM_OFF_LAST_ID 12'h018
`define OCM_OFF_ARB_BASE 12'h100

`define OCM_IRQ_W 4
`define OCM_IRQ_STORED 0
`define OCM_IRQ_IGNORED 1
`define OCM_IRQ_SPF_FIX 2
`define OCM_IRQ_MEC_CLAMP 3

`define OCM_ST_SP_FLAG 0
`define OCM_ST_MEC_A 1
`define OCM_ST_MEC_B 2
`define OCM_ST_LINK 3

`define OCM_SP_LIMIT_RST 16'h00C8
`define OCM_SPF_DEFAULT 16'h0064
`define OCM_SPF_MAX 16'h00C8
`define OCM_PCT_FULL 16'h0064
`define OCM_MEC_DEFAULT 32'h00000000
`define OCM_MEC_ONE_MM 32'h00004E20

`define OCM_ID_A_FIRST 16'h2300
`define OCM_ID_A_LAST 16'h230F
`define OCM_ID_B_FIRST 16'h2400
`define OCM_ID_B_LAST 16'h2403
`define OCM_ID_A_COUNT 5'h10

`endif

// >>> core/ocm_arb_store.v
/*
 arbitrary data word store: twenty records of four 16-bit word registers,
 written whole by identifier, read one word at a time.
 assumes the caller has already qualified the write with link activity.
*/
`timescale 1ns/1ps
`include "ocm_defines.vh"

module ocm_arb_store #(
	parameter NUM_IDS = 20,
	parameter IDX_W = 7
) (
	input wire pclk,
	input wire presetn,
	input wire clear,
	input wire wr_en,
	input wire [15:0] wr_id,
	input wire [63:0] wr_data,
	input wire [IDX_W-1:0] rd_idx,
	output wire [15:0] rd_word,
	output wire id_ok
);

	reg [15:0] words_r [0:NUM_IDS*4-1];
	integer i;

	//////////////////////////////////////////////////////////////////////////////
	function [5:0] id_group;
		input [15:0] id;
		begin
			if (id >= `OCM_ID_A_FIRST && id <= `OCM_ID_A_LAST) begin
				id_group = {2'b00, id[3:0]};
			end else if (id >= `OCM_ID_B_FIRST && id <= `OCM_ID_B_LAST) begin
				id_group = {1'b0, `OCM_ID_A_COUNT} + {4'h0, id[1:0]};
			end else begin
				id_group = 6'h3F;
			end
		end
	endfunction

	wire [5:0] grp = id_group(wr_id);
	assign id_ok = (grp < NUM_IDS);
	wire [IDX_W-1:0] base = {grp[IDX_W-3:0], 2'b00};

	assign rd_word = (rd_idx < NUM_IDS * 4) ? words_r[rd_idx] : 16'h0000;

	//////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < NUM_IDS * 4; i = i + 1) begin
				words_r[i] <= 16'h0000;
			end
		end else if (clear) begin
			for (i = 0; i < NUM_IDS * 4; i = i + 1) begin
				words_r[i] <= 16'h0000;
			end
		end else if (wr_en && id_ok) begin
			// byte 1 lands high in word 0, byte 8 low in word 3
			words_r[base] <= wr_data[63:48];
			words_r[base | 7'h01] <= wr_data[47:32];
			words_r[base | 7'h02] <= wr_data[31:16];
			words_r[base | 7'h03] <= wr_data[15:0];
		end
	end

endmodule

// >>> testbench/ocm_top_assertions.sv
/* port-level properties of the mapper top.
 assumes binding onto ocm_top with its port names. */
`timescale 1ns/1ps
module ocm_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire link_active,
	input wire cycle_start,
	input wire ctrl_reset,
	input wire emergency_stop,
	input wire [15:0] panel_spindle_ovr,
	input wire spindle_factor_valid,
	input wire [15:0] spindle_factor,
	input wire mec_valid,
	input wire [31:0] mec_existing,
	input wire [15:0] spindle_ovr_out,
	input wire spindle_comp_active_flag,
	input wire [31:0] mec_total_out,
	input wire machine_err_comp_flag_a,
	input wire machine_err_comp_flag_b
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire sp_use = cycle_start & link_active & spindle_factor_valid;
	wire mec_use = link_active & mec_valid;
	//////////////////////////////////////////////////////////////////////////////
	sequence s_bad;
		psel && !penable && paddr[1:0] != 2'h0 ##1 psel && penable;
	endsequence
	property p_bad_addr;
		s_bad |-> pslverr && prdata == 32'h0;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("misaligned access not refused");
	property p_sp_flag;
		$past(presetn) |-> spindle_comp_active_flag == $past(sp_use);
	endproperty
	a_sp_flag: assert property (p_sp_flag) else $error("spindle flag wrong");
	property p_mec_flags;
		$past(presetn) |-> machine_err_comp_flag_a == $past(mec_use)
			&& machine_err_comp_flag_b == $past(mec_use);
	endproperty
	a_mec_flags: assert property (p_mec_flags) else $error("error flags wrong");
	property p_mec_clamp;
		$past(presetn) |-> $signed(mec_total_out - $past(mec_existing)) <= 20000
			&& $signed(mec_total_out - $past(mec_existing)) >= -20000;
	endproperty
	a_mec_clamp: assert property (p_mec_clamp) else $error("error out of range");
	property p_mec_default;
		$past(presetn) && !$past(mec_use) |-> mec_total_out == $past(mec_existing);
	endproperty
	a_mec_default: assert property (p_mec_default) else $error("error default");
	property p_ovr_max;
		$past(presetn) |-> {1'b0, spindle_ovr_out} <= {$past(panel_spindle_ovr), 1'b0};
	endproperty
	a_ovr_max: assert property (p_ovr_max) else $error("factor above max");
	property p_neg_factor;
		$past(presetn) && $past(sp_use && spindle_factor[15])
			|-> spindle_ovr_out <= $past(panel_spindle_ovr);
	endproperty
	a_neg_factor: assert property (p_neg_factor) else $error("negative factor");
	property p_keep_on_reset;
		$past(presetn) && $past(mec_use && (ctrl_reset || emergency_stop))
			|-> machine_err_comp_flag_a && machine_err_comp_flag_b;
	endproperty
	a_keep_on_reset: assert property (p_keep_on_reset) else $error("stopped on reset");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind ocm_top ocm_chk u_chk (.*);

// >>> testbench/ocm_link_model.sv
/* link receiver model: presents one whole record per call.
 assumes a free-running pclk; caller enters just after an edge. */
`timescale 1ns/1ps
module ocm_link_model (
	input wire pclk,
	output reg rec_valid,
	output reg [15:0] rec_id,
	output reg [63:0] rec_data
);
	initial begin
		rec_valid = 1'b0;
		rec_id = 16'h0000;
		rec_data = 64'h0;
	end
	// all 8 bytes in one beat single sender owns enabled ids
	task send_rec(input [15:0] id, input [63:0] d);
		@(posedge pclk);
		rec_valid <= 1'b1;
		rec_id <= id;
		rec_data <= d;
		@(posedge pclk);
		rec_valid <= 1'b0;
		// inverted so a stale value never looks valid
		rec_id <= ~id;
		rec_data <= ~d;
	endtask
endmodule

// >>> testbench/tb.sv
/* self-checking bench for the mapper top over apb and the link model.
 assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module tb;
	logic pclk, presetn, psel, penable, pwrite, link_active, cycle_start, ctrl_reset;
	logic emergency_stop, ctrl_start, spindle_factor_valid, mec_valid, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, auto_spindle_speed, mec_value, mec_existing, rd;
	logic [15:0] panel_spindle_ovr, spindle_factor, id;
	logic [63:0] d;
	wire pready, pslverr, rec_valid, spindle_comp_active_flag, irq;
	wire machine_err_comp_flag_a, machine_err_comp_flag_b;
	wire [31:0] prdata, spindle_speed_out, mec_total_out;
	wire [15:0] rec_id, spindle_ovr_out;
	wire [63:0] rec_data;
	int err_count, comparisons, cyc;
	logic [15:0] pn[5] = '{16'h0064, 16'h0064, 16'h0064, 16'h0096, 16'h0096};
	logic [15:0] fc[5] = '{16'hFFFB, 16'h012C, 16'h0096, 16'h00C8, 16'h0032};
	logic [15:0] eo[5] = '{16'h0064, 16'h00C8, 16'h0096, 16'h00C8, 16'h0096};
	logic cs[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic [31:0] mv[4] = '{32'h00007530, 32'hFFFF8AD0, 32'h000001F4, 32'h000001F4};
	logic [31:0] me[4] = '{32'h00004E84, 32'hFFFFB244, 32'h00000258, 32'h00000064};
	ocm_top u_dut (.*);
	ocm_link_model u_link (.pclk(pclk), .rec_valid(rec_valid), .rec_id(rec_id),
		.rec_data(rec_data));
	//////////////////////////////////////////////////////////////////////////////
	task close_out;
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input [63:0] exp, input [63:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdw(input [6:0] k, input [15:0] exp);
		apb(1'b0, 12'h100 + {3'h0, k, 2'h0}, 32'h0);
		chk("arb word", {48'h0, exp}, rd);
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, link_active, cycle_start, ctrl_reset} = 7'h0;
		{emergency_stop, ctrl_start, spindle_factor_valid, mec_valid} = 4'h0;
		{paddr, pwdata, auto_spindle_speed, mec_value, mec_existing} = 140'h0;
		{panel_spindle_ovr, spindle_factor} = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h014, 32'h0);
		chk("limit reset", 64'hC8, rd);
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped err", 64'h1, err);
		apb(1'b1, 12'h008, 32'hF);
		chk("read-only err", 64'h1, err);
		link_active <= 1'b1;
		for (int g = 0; g < 20; g++) begin
			id = (g < 16) ? 16'h2300 + g[15:0] : 16'h23F0 + g[15:0];
			d = 64'h1021324354657687 ^ {8{g[7:0]}};
			u_link.send_rec(id, d);
			for (int j = 0; j < 4; j++)
				rdw(7'(4 * g + j), d[63 - 16 * j -: 16]);
		end
		apb(1'b0, 12'h018, 32'h0);
		chk("last id", 64'h2403, rd);
		apb(1'b0, 12'h016, 32'h0);
		chk("misaligned err", 64'h1, err);
		chk("misaligned data", 64'h0, rd);
		link_active <= 1'b0;
		u_link.send_rec(16'h2300, 64'h0);
		rdw(7'h0, 16'h1021);
		link_active <= 1'b1;
		apb(1'b1, 12'h004, 32'h0);
		apb(1'b1, 12'h000, 32'hF);
		u_link.send_rec(16'h2404, 64'h0);
		rdw(7'h0, 16'h1021);
		rdw(7'd79, 16'h6594);
		chk("irq masked", 64'h0, irq);
		apb(1'b1, 12'h004, 32'h2);
		#1 chk("irq raised", 64'h1, irq);
		apb(1'b0, 12'h000, 32'h0);
		chk("irq status", 64'h2, rd[3:0]);
		apb(1'b1, 12'h000, 32'h2);
		#1 chk("irq cleared", 64'h0, irq);
		@(posedge pclk);
		ctrl_start <= 1'b1;
		@(posedge pclk);
		ctrl_start <= 1'b0;
		rdw(7'h0, 16'h0);
		rdw(7'd79, 16'h0);
		spindle_factor_valid <= 1'b1;
		auto_spindle_speed <= 32'h3E8;
		for (int i = 0; i < 5; i++) begin
			@(posedge pclk);
			panel_spindle_ovr <= pn[i];
			spindle_factor <= fc[i];
			cycle_start <= cs[i];
			repeat (2) @(posedge pclk);
			#1 chk("spindle ovr", eo[i], spindle_ovr_out);
			chk("spindle speed", 10 * eo[i], spindle_speed_out);
			chk("spindle flag", cs[i], spindle_comp_active_flag);
		end
		mec_existing <= 32'h64;
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			mec_value <= mv[i];
			mec_valid <= (i != 3);
			ctrl_reset <= (i == 2);
			emergency_stop <= (i == 2);
			repeat (2) @(posedge pclk);
			#1 chk("mec total", me[i], mec_total_out);
			chk("mec flags", {2{i != 3}},
				{machine_err_comp_flag_a, machine_err_comp_flag_b});
		end
		apb(1'b0, 12'h000, 32'h0);
		chk("irq events", 64'hC, rd[3:0]);
		apb(1'b0, 12'h008, 32'h0);
		chk("status", 64'h8, rd);
		close_out();
	end
endmodule
